// *** rtl/pcr_pkg.sv ***
// package: register map, field positions and carrier types of the copper event register bank
// ****************************************************************************
// Notes on behaviour
// - auto-negotiation error flag latches on resolution, parallel, capability or no-link faults
// - bit 14 latches on speed change, bit 13 on duplex change
// - bit 12 latches on page received, bit 11 on negotiation complete
// - bit 10 latches whenever copper link goes up or down
// - bit 9 latches on symbol error, bit 8 on false carrier
// - bit 6 latches on crossover change, bit 5 on downshift
// - bit 4 latches whenever energy-detect state changes
// - bit 3 latches when pulse exchange ends without a link
// - bit 1 latches on receive polarity change, bit 0 on jabber
// - bits 7 and 2 of event status always read zero
// - each pair's transmit polarity inverts when its control bit is one
// - receive error counter saturates at all ones instead of wrapping
// - counter counts both false carriers and symbol errors
// - eight-bit page select, hardware reset to zero, kept over software reset
// - page select upper byte reads zero
// - writing one to control bit 10 restarts negotiation, then self-clears
// - interrupt raised only for flags whose enable bit is set
// ****************************************************************************
`default_nettype none
package pcr_pkg;
    // register indices; byte address is four times the index
    localparam logic [5:0] PCR_IDX_SOFT_RESET = 6'h00;
    localparam logic [5:0] PCR_IDX_INT_EN     = 6'h12;
    localparam logic [5:0] PCR_IDX_EVT_STATUS = 6'h13;
    localparam logic [5:0] PCR_IDX_TX_POL     = 6'h14;
    localparam logic [5:0] PCR_IDX_RX_ERR     = 6'h15;
    localparam logic [5:0] PCR_IDX_PAGE_SEL   = 6'h16;
    localparam logic [5:0] PCR_IDX_NEG_CTRL   = 6'h19;

    // event-status field positions
    localparam int PCR_B_AN_ERR    = 15;
    localparam int PCR_B_SPEED     = 14;
    localparam int PCR_B_DUPLEX    = 13;
    localparam int PCR_B_PAGE      = 12;
    localparam int PCR_B_AN_DONE   = 11;
    localparam int PCR_B_LINK      = 10;
    localparam int PCR_B_SYMBOL    = 9;
    localparam int PCR_B_FALSE_CAR = 8;
    localparam int PCR_B_RSVD_HI   = 7;
    localparam int PCR_B_MDIX      = 6;
    localparam int PCR_B_DOWNSHIFT = 5;
    localparam int PCR_B_ENERGY    = 4;
    localparam int PCR_B_FLP_NOLNK = 3;
    localparam int PCR_B_RSVD_LO   = 2;
    localparam int PCR_B_POLARITY  = 1;
    localparam int PCR_B_JABBER    = 0;
    localparam logic [15:0] PCR_EVT_MASK = 16'hFF7B;

    // negotiation control, soft reset and page fields
    localparam int PCR_B_RESTART  = 10;
    localparam int PCR_B_GIG_DIS  = 6;
    localparam int PCR_B_LOW_PWR  = 2;
    localparam int PCR_B_SOFT_RST = 15;
    localparam int PCR_PAGE_W     = 8;
    localparam int PCR_PAIRS      = 4;

    localparam logic [15:0] PCR_RST16    = 16'h0000;
    localparam logic [15:0] PCR_CNT_MAX  = 16'hFFFF;
    localparam logic [1:0]  PCR_RESP_OK  = 2'h0;
    localparam logic [1:0]  PCR_RESP_ERR = 2'h2;

    // status levels and event pulses from the copper core, same clock
    typedef struct packed {
        logic       an_ms_fault;
        logic       an_pd_fault;
        logic       an_no_hcc;
        logic       an_no_link;
        logic [1:0] speed;
        logic       duplex_full;
        logic       page_rx;
        logic       an_done;
        logic       link_up;
        logic       sym_err;
        logic       false_carrier;
        logic       mdix;
        logic       downshift;
        logic       energy_sleep;
        logic       link_pulse_burst_no_link;
        logic       rx_pol_rev;
        logic       jabber;
    } pcr_evt_t;

    // controls toward the copper core
    typedef struct packed {
        logic [PCR_PAIRS-1:0]  tx_pol_invert;
        logic [PCR_PAGE_W-1:0] page_sel;
        logic                  gigabit_disable;
        logic                  low_power_link_select;
        logic                  restart_aneg;
        logic                  phy_int;
    } pcr_ctl_t;
endpackage
`default_nettype wire

// *** rtl/pcr_event_regs.sv ***
// module: copper event status, polarity, error counter, page and control registers on axi4-lite
//
// The AXI4-Lite slave port was decided locally.
`default_nettype none
module pcr_event_regs
    import pcr_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire pcr_evt_t          evt_in,
    output pcr_ctl_t               ctl_out
);
    // ************************************************************************
    // helpers
    // ************************************************************************
    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [31:0] d,
                                            input logic [3:0]  s);
        merge16 = {s[1] ? d[15:8] : old_v[15:8], s[0] ? d[7:0] : old_v[7:0]};
    endfunction

    function automatic logic mapped(input logic [5:0] idx);
        mapped = (idx == PCR_IDX_SOFT_RESET) || (idx == PCR_IDX_INT_EN) ||
                 (idx == PCR_IDX_EVT_STATUS) || (idx == PCR_IDX_TX_POL) ||
                 (idx == PCR_IDX_RX_ERR) || (idx == PCR_IDX_PAGE_SEL) ||
                 (idx == PCR_IDX_NEG_CTRL);
    endfunction

    function automatic logic [5:0] word_idx(input logic [ADDR_W-1:0] a);
        word_idx = 6'(a >> 2);
    endfunction
    // ************************************************************************
    // bus slave state
    // ************************************************************************
    logic              awready_r;
    logic              wready_r;
    logic              bvalid_r;
    logic [1:0]        bresp_r;
    logic              arready_r;
    logic              rvalid_r;
    logic [31:0]       rdata_r;
    logic [1:0]        rresp_r;
    logic              aw_hold_r;
    logic              w_hold_r;
    logic [5:0]        wr_idx_r;
    logic              wr_top_r;
    logic [31:0]       wdata_r;
    logic [3:0]        wstrb_r;
    // register state
    logic [15:0]       evt_r;
    logic [15:0]       int_en_r;
    logic [11:0]       tx_pol_hi_r;
    logic [15:0]       rx_err_r;
    pcr_ctl_t          ctl_r;
    logic              sw_rst_r;
    // history of the level inputs for change detection
    logic [1:0]        speed_q_r;
    logic              duplex_q_r;
    logic              link_q_r;
    logic              mdix_q_r;
    logic              energy_q_r;
    logic              pol_q_r;
    logic              hist_ok_r;
    logic              wr_fire;
    logic              ar_fire;
    logic [5:0]        rd_idx;
    logic              rd_top_ok;
    logic              evt_rd;
    logic              cnt_rd;
    logic [15:0]       evt_set;
    logic [15:0]       rd_word;
    logic [1:0]        cnt_inc;
    logic [16:0]       cnt_sum;
    assign wr_fire   = aw_hold_r && w_hold_r && !bvalid_r;
    assign ar_fire   = s_axi_arvalid && arready_r;
    assign rd_idx    = word_idx(s_axi_araddr);
    // only the low eight address bits decode; anything above must be zero
    assign rd_top_ok = (s_axi_araddr >> 8) == '0;
    assign evt_rd    = ar_fire && rd_top_ok && (rd_idx == PCR_IDX_EVT_STATUS);
    assign cnt_rd    = ar_fire && rd_top_ok && (rd_idx == PCR_IDX_RX_ERR);
    // ************************************************************************
    // write channels: address and data accepted in either order
    // ************************************************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            awready_r <= 1'b1;
            aw_hold_r <= 1'b0;
            wr_idx_r  <= 6'h00;
            wr_top_r  <= 1'b0;
        end else if (s_axi_awvalid && awready_r) begin
            awready_r <= 1'b0;
            aw_hold_r <= 1'b1;
            wr_idx_r  <= word_idx(s_axi_awaddr);
            wr_top_r  <= (s_axi_awaddr >> 8) == '0;
        end else if (wr_fire) begin
            aw_hold_r <= 1'b0;
        end else if (bvalid_r && s_axi_bready) begin
            awready_r <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wready_r <= 1'b1;
            w_hold_r <= 1'b0;
            wdata_r  <= 32'h0000_0000;
            wstrb_r  <= 4'h0;
        end else if (s_axi_wvalid && wready_r) begin
            wready_r <= 1'b0;
            w_hold_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_hold_r <= 1'b0;
        end else if (bvalid_r && s_axi_bready) begin
            wready_r <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bvalid_r <= 1'b0;
            bresp_r  <= PCR_RESP_OK;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r  <= (wr_top_r && mapped(wr_idx_r)) ? PCR_RESP_OK : PCR_RESP_ERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end
    // ************************************************************************
    // read channel: data sampled at acceptance, so read-clear sees the same word
    // ************************************************************************
    always_comb begin
        rd_word = 16'h0000;
        case (rd_idx)
            PCR_IDX_INT_EN:     rd_word = int_en_r;
            PCR_IDX_EVT_STATUS: rd_word = evt_r & PCR_EVT_MASK;
            PCR_IDX_TX_POL:     rd_word = {tx_pol_hi_r, ctl_r.tx_pol_invert};
            PCR_IDX_RX_ERR:     rd_word = rx_err_r;
            PCR_IDX_PAGE_SEL:   rd_word = {8'h00, ctl_r.page_sel};
            PCR_IDX_NEG_CTRL: begin
                rd_word[PCR_B_RESTART] = ctl_r.restart_aneg;
                rd_word[PCR_B_GIG_DIS] = ctl_r.gigabit_disable;
                rd_word[PCR_B_LOW_PWR] = ctl_r.low_power_link_select;
            end
            default:            rd_word = 16'h0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= PCR_RESP_OK;
        end else if (ar_fire) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b1;
            rdata_r   <= {16'h0000, rd_top_ok ? rd_word : 16'h0000};
            rresp_r   <= (rd_top_ok && mapped(rd_idx)) ? PCR_RESP_OK : PCR_RESP_ERR;
        end else if (rvalid_r && s_axi_rready) begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
        end
    end
    // ************************************************************************
    // software reset pulse
    // ************************************************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sw_rst_r <= 1'b0;
        end else begin
            sw_rst_r <= wr_fire && wr_top_r && (wr_idx_r == PCR_IDX_SOFT_RESET) &&
                        wstrb_r[1] && wdata_r[PCR_B_SOFT_RST];
        end
    end
    // ************************************************************************
    // event detection and latched flags
    // ************************************************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            {speed_q_r, duplex_q_r, link_q_r, mdix_q_r, energy_q_r, pol_q_r} <= 7'h00;
            hist_ok_r <= 1'b0;
        end else begin
            {speed_q_r, duplex_q_r, link_q_r, mdix_q_r, energy_q_r, pol_q_r} <=
                {evt_in.speed, evt_in.duplex_full, evt_in.link_up, evt_in.mdix,
                 evt_in.energy_sleep, evt_in.rx_pol_rev};
            hist_ok_r <= 1'b1;
        end
    end
    // no change is reported until one sample of history exists after reset
    always_comb begin
        evt_set                  = 16'h0000;
        evt_set[PCR_B_AN_ERR]    = evt_in.an_ms_fault || evt_in.an_pd_fault ||
                                   evt_in.an_no_hcc || evt_in.an_no_link;
        evt_set[PCR_B_SPEED]     = hist_ok_r && (evt_in.speed != speed_q_r);
        evt_set[PCR_B_DUPLEX]    = hist_ok_r && (evt_in.duplex_full != duplex_q_r);
        evt_set[PCR_B_PAGE]      = evt_in.page_rx;
        evt_set[PCR_B_AN_DONE]   = evt_in.an_done;
        evt_set[PCR_B_LINK]      = hist_ok_r && (evt_in.link_up != link_q_r);
        evt_set[PCR_B_SYMBOL]    = evt_in.sym_err;
        evt_set[PCR_B_FALSE_CAR] = evt_in.false_carrier;
        evt_set[PCR_B_MDIX]      = hist_ok_r && (evt_in.mdix != mdix_q_r);
        evt_set[PCR_B_DOWNSHIFT] = evt_in.downshift;
        evt_set[PCR_B_ENERGY]    = hist_ok_r && (evt_in.energy_sleep != energy_q_r);
        evt_set[PCR_B_FLP_NOLNK] = evt_in.link_pulse_burst_no_link;
        evt_set[PCR_B_POLARITY]  = hist_ok_r && (evt_in.rx_pol_rev != pol_q_r);
        evt_set[PCR_B_JABBER]    = evt_in.jabber;
    end

    // an event landing in the read-clear cycle stays latched for the next read
    always_ff @(posedge clk) begin
        if (sys_rst || sw_rst_r) begin
            evt_r <= PCR_RST16;
        end else if (evt_rd) begin
            evt_r <= evt_set & PCR_EVT_MASK;
        end else begin
            evt_r <= (evt_r | evt_set) & PCR_EVT_MASK;
        end
    end
    // ************************************************************************
    // receive error counter, kept over software reset
    // ************************************************************************
    assign cnt_inc = {1'b0, evt_in.sym_err} + {1'b0, evt_in.false_carrier};
    assign cnt_sum = {1'b0, cnt_rd ? 16'h0000 : rx_err_r} + {15'h0000, cnt_inc};

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rx_err_r <= PCR_RST16;
        end else if (cnt_sum[16]) begin
            rx_err_r <= PCR_CNT_MAX;
        end else begin
            rx_err_r <= cnt_sum[15:0];
        end
    end
    // ************************************************************************
    // software-written controls
    // ************************************************************************
    logic wr_ok;
    assign wr_ok = wr_fire && wr_top_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            int_en_r <= PCR_RST16;
        end else if (wr_ok && wr_idx_r == PCR_IDX_INT_EN) begin
            int_en_r <= merge16(int_en_r, wdata_r, wstrb_r) & PCR_EVT_MASK;
        end
    end
    // polarity register and page select are untouched by the software reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tx_pol_hi_r         <= 12'h000;
            ctl_r.tx_pol_invert <= 4'h0;
        end else if (wr_ok && wr_idx_r == PCR_IDX_TX_POL) begin
            {tx_pol_hi_r, ctl_r.tx_pol_invert} <= merge16({tx_pol_hi_r,
                                                  ctl_r.tx_pol_invert}, wdata_r, wstrb_r);
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctl_r.page_sel <= 8'h00;
        end else if (wr_ok && wr_idx_r == PCR_IDX_PAGE_SEL && wstrb_r[0]) begin
            ctl_r.page_sel <= wdata_r[7:0];
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctl_r.gigabit_disable       <= 1'b0;
            ctl_r.low_power_link_select <= 1'b0;
        end else if (wr_ok && wr_idx_r == PCR_IDX_NEG_CTRL && wstrb_r[0]) begin
            ctl_r.gigabit_disable       <= wdata_r[PCR_B_GIG_DIS];
            ctl_r.low_power_link_select <= wdata_r[PCR_B_LOW_PWR];
        end
    end
    // restart is a one-cycle pulse toward the negotiation engine
    always_ff @(posedge clk) begin
        if (sys_rst || sw_rst_r) begin
            ctl_r.restart_aneg <= 1'b0;
        end else begin
            ctl_r.restart_aneg <= wr_ok && wr_idx_r == PCR_IDX_NEG_CTRL &&
                                  wstrb_r[1] && wdata_r[PCR_B_RESTART];
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctl_r.phy_int <= 1'b0;
        end else begin
            ctl_r.phy_int <= |(evt_r & int_en_r);
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready  = wready_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;
    assign ctl_out       = ctl_r;

    // ************************************************************************
    // checks
    // ************************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_read_taken;
        ar_fire ##1 rvalid_r;
    endsequence

    a_read_answer: assert property (ar_fire |-> s_read_taken)
        else $error("read answer not one cycle after acceptance");
    a_an_error: assert property ((evt_in.an_no_hcc && !sw_rst_r) |=> evt_r[PCR_B_AN_ERR])
        else $error("negotiation error not latched");
    a_speed_flag: assert property ((hist_ok_r && evt_in.speed != speed_q_r && !sw_rst_r)
        |=> evt_r[PCR_B_SPEED])
        else $error("speed change not latched");
    a_link_flag: assert property ((hist_ok_r && evt_in.link_up != link_q_r && !sw_rst_r)
        |=> evt_r[PCR_B_LINK])
        else $error("link change not latched");
    a_flag_hold: assert property ((evt_r[PCR_B_JABBER] && !evt_rd && !sw_rst_r)
        |=> evt_r[PCR_B_JABBER])
        else $error("latched flag lost without read");
    a_read_clears: assert property ((evt_rd && evt_set == 16'h0000 && !sw_rst_r)
        ##1 rvalid_r |-> evt_r == 16'h0000)
        else $error("event read did not clear flags");
    a_rsvd_zero: assert property (evt_rd |=> (rdata_r[7] == 1'b0 && rdata_r[2] == 1'b0))
        else $error("reserved status bit read as one");
    a_cnt_saturate: assert property ((rx_err_r == PCR_CNT_MAX && !cnt_rd)
        |=> rx_err_r == PCR_CNT_MAX)
        else $error("error counter wrapped");
    a_cnt_count: assert property ((evt_in.sym_err && evt_in.false_carrier && !cnt_rd &&
        rx_err_r < 16'hFFF0) |=> rx_err_r == $past(rx_err_r) + 16'h0002)
        else $error("error counter missed an event");
    a_pol_write: assert property ((wr_ok && wr_idx_r == PCR_IDX_TX_POL && wstrb_r[0])
        |=> ctl_r.tx_pol_invert == $past(wdata_r[3:0]))
        else $error("transmit polarity not updated");
    a_page_keep: assert property (sw_rst_r |-> $stable(ctl_r.page_sel))
        else $error("page select lost on software reset");
    a_page_upper: assert property ((ar_fire && rd_idx == PCR_IDX_PAGE_SEL)
        |=> rdata_r[15:8] == 8'h00)
        else $error("page select upper byte nonzero");
    a_restart_self: assert property (ctl_r.restart_aneg |=> !ctl_r.restart_aneg)
        else $error("restart bit did not self-clear");
    a_int_gate: assert property (((evt_r & int_en_r) == 16'h0000) |=> !ctl_r.phy_int)
        else $error("interrupt raised without enabled flag");

endmodule
`default_nettype wire

// *** verification/pcr_event_regs_test.sv ***
// testbench: copper event register bank driven over axi4-lite
`default_nettype none
module pcr_event_regs_test
    import pcr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [17:0] PULSES = 18'h3C6D5;
    localparam logic [15:0] EXP[18] = '{16'h0001, 16'h0002, 16'h0008, 16'h0010, 16'h0020,
        16'h0040, 16'h0100, 16'h0200, 16'h0400, 16'h0800, 16'h1000, 16'h2000, 16'h4000,
        16'h4000, 16'h8000, 16'h8000, 16'h8000, 16'h8000};
    logic        clk, sys_rst, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, pulse_seen;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rq;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, resp;
    pcr_evt_t    evt;
    pcr_ctl_t    ctl;
    int          num_errors, n_checks;

    pcr_event_regs i_pcr_event_regs (.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .evt_in(evt), .ctl_out(ctl));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // ****************************************
    // bus and compare helpers
    // ****************************************
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // samples right after the edge, so design registers still show their pre-edge values
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        awaddr  <= a;
        wdata   <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        forever begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                resp = bresp;
                pulse_seen = ctl.restart_aneg;
                bready <= 1'b0;
                break;
            end
        end
        @(posedge clk);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        forever begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                rq = rdata;
                resp = rresp;
                rready <= 1'b0;
                break;
            end
        end
        @(posedge clk);
        chk($sformatf("reg %h", a), rq, {16'h0000, exp});
    endtask
    // levels stay toggled, pulses last one cycle
    task automatic ev(input logic [17:0] m);
        evt <= evt ^ m;
        @(posedge clk);
        evt <= evt & ~PULSES;
        @(posedge clk);
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        foreach (EXP[i]) if (i < 5) rdchk(8'h4C + 8'(4 * i), 16'h0000);
        rdchk(8'h64, 16'h0000);
        chk("ctl", ctl, '0);
        rdchk(8'hFC, 16'h0000);
        chk("rresp", resp, PCR_RESP_ERR);
    endtask
    task automatic t_events();
        for (int i = 0; i < 18; i++) begin
            ev(18'(1) << i);
            rdchk(8'h4C, EXP[i]);
        end
        rdchk(8'h4C, 16'h0000);
        rdchk(8'h54, 16'h0002);
        ev(18'h000C0);
        rdchk(8'h54, 16'h0002);
    endtask
    task automatic t_saturate();
        evt <= evt | 18'h000C0;
        repeat (32800) @(posedge clk);
        evt <= evt & ~PULSES;
        @(posedge clk);
        rdchk(8'h54, 16'hFFFF);
        rdchk(8'h54, 16'h0000);
        rdchk(8'h4C, 16'h0300);
    endtask
    task automatic t_ctrl();
        wr(8'h50, 16'h000F);
        chk("tx_pol", ctl.tx_pol_invert, 4'hF);
        wr(8'h50, 16'h0005);
        chk("tx_pol", ctl.tx_pol_invert, 4'h5);
        wr(8'h58, 16'hFFFF);
        chk("page", ctl.page_sel, 8'hFF);
        rdchk(8'h58, 16'h00FF);
        wr(8'h64, 16'hFFFF);
        chk("restart", pulse_seen, 1'b1);
        rdchk(8'h64, 16'h0044);
        chk("gig_lp", {ctl.gigabit_disable, ctl.low_power_link_select}, 2'h3);
        wr(8'hFC, 16'h1234);
        chk("bresp", resp, PCR_RESP_ERR);
    endtask
    task automatic t_irq();
        wr(8'h48, 16'h0001);
        rdchk(8'h48, 16'h0001);
        ev(18'h00001);
        @(posedge clk);
        chk("phy_int", ctl.phy_int, 1'b1);
        rdchk(8'h4C, 16'h0001);
        @(posedge clk);
        chk("phy_int", ctl.phy_int, 1'b0);
        ev(18'h00004);
        @(posedge clk);
        chk("phy_int", ctl.phy_int, 1'b0);
    endtask
    task automatic t_soft();
        ev(18'h00100);
        wr(8'h00, 16'h8000);
        repeat (2) @(posedge clk);
        rdchk(8'h4C, 16'h0000);
        rdchk(8'h50, 16'h0005);
        rdchk(8'h58, 16'h00FF);
        rdchk(8'h64, 16'h0044);
        sys_rst <= 1'b1;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        rdchk(8'h58, 16'h0000);
        rdchk(8'h64, 16'h0000);
    endtask

    initial begin
        {awvalid, wvalid, bready, arvalid, rready, pulse_seen} = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
        evt = '0;
        sys_rst = 1'b1;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_events();
        t_saturate();
        t_ctrl();
        t_irq();
        t_soft();
        report_and_stop();
    end
    // the saturation run dominates; a hang anywhere ends well after it
    initial begin
        repeat (50000) @(posedge clk);
        num_errors++;
        report_and_stop();
    end
endmodule
`default_nettype wire
